// file: pkg/rwwc_consts.svh
// constants for the reset, wakeup and watchdog control block
// assumes inclusion by bare name from pkg/ and hdl/ files
`ifndef RWWC_CONSTS_SVH
`define RWWC_CONSTS_SVH
`define RWWC_ADDR_W           13
`define RWWC_WDOG_CLR_ADDR    13'h1ff0
`define RWWC_WDOG_CLR_BIT     0
`define RWWC_VEC_RESET        13'h1ffe
`define RWWC_VEC_EXT          13'h1ffa
`define RWWC_VEC_TIMER        13'h1ff8
`define RWWC_VEC_SERIAL       13'h1ff6
`define RWWC_VEC_SPI          13'h1ff4
`define RWWC_POR_CYCLES       4064
`define RWWC_WDOG_BITS        18
`define RWWC_PIN_RST_CYCLES   2
`define RWWC_PORTB_W          8
`endif

// file: pkg/rwwc_pkg.sv
// types for the reset, wakeup and watchdog control block
// assumes rwwc_consts.svh is on the include path
package rwwc_pkg;
	`include "rwwc_consts.svh"
	typedef enum logic [1:0] {
		RWWC_RUN,
		RWWC_WAIT,
		RWWC_STOP
	} rwwc_mode_e;
	typedef enum logic [1:0] {
		RWWC_RST_IDLE,
		RWWC_RST_HOLD,
		RWWC_RST_PIN
	} rwwc_rst_e;
	typedef struct packed {
		logic [2:0] timer_flags;
		logic [2:0] timer_en;
		logic [4:0] serial_flags;
		logic [4:0] serial_en;
		logic [1:0] spi_flags;
		logic [1:0] spi_en;
	} rwwc_periph_s;
	typedef struct packed {
		logic                     valid;
		logic [`RWWC_ADDR_W-1:0]  vector;
	} rwwc_vec_s;
endpackage : rwwc_pkg

// file: hdl/rwwc_sync.sv
// three-stage input synchroniser with agreement filter
// assumes inputs are asynchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module rwwc_sync #(
	parameter int          W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// data
	input  wire logic [W-1:0] d_i,
	output var  logic [W-1:0] q_o
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= RST;
			s2_q <= RST;
			s3_q <= RST;
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_agree
			always_ff @(posedge clk_i) begin
				if (rst_i)
					q_o[g] <= RST[g];
				else if (s2_q[g] == s3_q[g])
					q_o[g] <= s3_q[g];
			end
		end
	endgenerate
endmodule : rwwc_sync
`default_nettype wire

// file: hdl/rwwc_wdog.sv
// watchdog counter: 18-bit count, terminal count gives a one-cycle timeout
// assumes tick_i is the bus-cycle enable and clear_i is a one-cycle request
`timescale 1ns/1ps
`default_nettype none
`include "rwwc_consts.svh"
module rwwc_wdog #(
	parameter int W = `RWWC_WDOG_BITS
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// control
	input  wire logic enable_i,
	input  wire logic tick_i,
	input  wire logic clear_i,
	// status
	output var  logic timeout_o,
	output var  logic [W-1:0] count_o
);
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i || !enable_i) begin
			count_o   <= '0;
			timeout_o <= 1'b0;
		end else if (tick_i) begin
			count_o   <= count_o + 1'b1;
			timeout_o <= &count_o;
		end else begin
			timeout_o <= 1'b0;
		end
	end
endmodule : rwwc_wdog
`default_nettype wire

// file: hdl/rwwc_ctrl.sv
// reset, wakeup and watchdog control: interrupt latch, vectors, reset and low-power modes
// assumes the core reports instruction end, stop/wait entry and latch clear as pulses
`timescale 1ns/1ps
`default_nettype none
`include "rwwc_consts.svh"
module rwwc_ctrl
	import rwwc_pkg::*;
#(
	parameter int  POR_CYCLES  = `RWWC_POR_CYCLES,
	parameter bit  LEVEL_TRIG  = 1'b0,
	parameter bit  WDOG_OPTION = 1'b1,
	parameter int  BUS_DIV     = 2,
	parameter logic [`RWWC_PORTB_W-1:0] PORTB_IRQ_EN = '0
) (
	// clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	// pins
	input  wire logic                     ext_irq_n_i,
	input  wire logic                     reset_n_i,
	input  wire logic [`RWWC_PORTB_W-1:0] portb_i,
	input  wire logic                     self_check_i,
	// core bus
	input  wire logic                     bus_wr_i,
	input  wire logic                     bus_rd_i,
	input  wire logic [`RWWC_ADDR_W-1:0]  bus_addr_i,
	input  wire logic [7:0]               bus_wdata_i,
	input  wire logic [7:0]               rom_byte_i,
	output logic      [7:0]               bus_rdata_o,
	// core handshake
	input  wire logic                     insn_end_i,
	input  wire logic                     ext_latch_clr_i,
	input  wire logic                     mask_set_i,
	input  wire logic                     mask_clr_i,
	input  wire logic                     stop_req_i,
	input  wire logic                     wait_req_i,
	input  wire rwwc_periph_s             periph_i,
	// outputs
	output logic                          sys_rst_o,
	output logic                          mask_o,
	output rwwc_vec_s                     vec_o,
	output logic                          core_run_o,
	output logic                          osc_en_o,
	output logic                          timer_en_clr_o,
	output logic                          prescaler_clr_o,
	output logic                          wdog_timeout_o
);
	localparam int PCW = $clog2(POR_CYCLES + 1);
	localparam int BDW = (BUS_DIV > 1) ? $clog2(BUS_DIV) : 1;
	localparam logic [PCW-1:0] POR_LAST = PCW'(POR_CYCLES - 1);
	localparam logic [PCW-1:0] PIN_LAST = PCW'(`RWWC_PIN_RST_CYCLES - 1);

	logic                     irq_n_s;
	logic                     rst_n_s;
	logic [`RWWC_PORTB_W-1:0] portb_s;
	rwwc_sync #(.W(1), .RST(1'b1)) u_sync_irq (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (ext_irq_n_i),
		.q_o   (irq_n_s)
	);
	rwwc_sync #(.W(1), .RST(1'b1)) u_sync_rst (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (reset_n_i),
		.q_o   (rst_n_s)
	);
	rwwc_sync #(.W(`RWWC_PORTB_W), .RST({`RWWC_PORTB_W{1'b1}})) u_sync_pb (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (portb_i),
		.q_o   (portb_s)
	);

	// combined active-low source: pin and enabled port B pins
	logic ext_line_n;
	logic ext_line_n_q;
	assign ext_line_n = irq_n_s & ~|(~portb_s & PORTB_IRQ_EN);
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ext_line_n_q <= 1'b1;
		else
			ext_line_n_q <= ext_line_n;
	end
	wire ext_fall = ext_line_n_q & ~ext_line_n;

	// reset sequencer
	rwwc_rst_e        rst_st_q;
	logic [PCW-1:0]   rst_cnt_q;
	logic [PCW-1:0]   rst_len_q;
	logic [PCW-1:0]   low_cnt_q;
	logic             wdog_to;
	logic             pin_rst;
	// pin reset only after the minimum low time, so short glitches are ignored
	always_ff @(posedge clk_i) begin
		if (rst_i || rst_n_s)
			low_cnt_q <= '0;
		else if (low_cnt_q != PIN_LAST)
			low_cnt_q <= low_cnt_q + 1'b1;
	end
	assign pin_rst = !rst_n_s && (low_cnt_q == PIN_LAST);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rst_st_q  <= RWWC_RST_HOLD;
			rst_cnt_q <= '0;
			rst_len_q <= POR_LAST;
			sys_rst_o <= 1'b1;
		end else begin
			case (rst_st_q)
				RWWC_RST_IDLE: begin
					if (pin_rst || wdog_to) begin
						rst_st_q  <= RWWC_RST_HOLD;
						rst_cnt_q <= '0;
						rst_len_q <= PIN_LAST;
						sys_rst_o <= 1'b1;
					end
				end
				RWWC_RST_HOLD: begin
					if (rst_cnt_q == rst_len_q)
						rst_st_q <= RWWC_RST_PIN;
					else
						rst_cnt_q <= rst_cnt_q + 1'b1;
				end
				RWWC_RST_PIN: begin
					if (rst_n_s) begin
						rst_st_q  <= RWWC_RST_IDLE;
						sys_rst_o <= 1'b0;
					end
				end
				default: begin
					rst_st_q  <= RWWC_RST_HOLD;
					sys_rst_o <= 1'b1;
				end
			endcase
		end
	end

	// low-power mode
	rwwc_mode_e mode_q;
	// reset entry counts in its own edge, so mask and vector move with sys_rst_o
	wire rst_go = (rst_st_q == RWWC_RST_IDLE) && (pin_rst || wdog_to);
	wire in_rst = sys_rst_o || rst_go;
	wire tim_req = |(periph_i.timer_flags & periph_i.timer_en);
	wire ser_req = |(periph_i.serial_flags & periph_i.serial_en);
	wire spi_req = |(periph_i.spi_flags & periph_i.spi_en);
	logic ext_pend_q;
	wire ext_req = ext_pend_q | (LEVEL_TRIG & ~ext_line_n);
	wire stop_enter = (mode_q == RWWC_RUN) && stop_req_i && !in_rst;
	wire wait_enter = (mode_q == RWWC_RUN) && wait_req_i && !stop_req_i && !in_rst;

	always_ff @(posedge clk_i) begin
		if (rst_i || in_rst) begin
			mode_q <= RWWC_RUN;
		end else begin
			case (mode_q)
				RWWC_RUN: begin
					if (stop_enter)
						mode_q <= RWWC_STOP;
					else if (wait_enter)
						mode_q <= RWWC_WAIT;
				end
				RWWC_WAIT: begin
					if (ext_req || tim_req || ser_req || spi_req)
						mode_q <= RWWC_RUN;
				end
				RWWC_STOP: begin
					if (ext_req)
						mode_q <= RWWC_RUN;
				end
				default: mode_q <= RWWC_RUN;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_run_o      <= 1'b0;
			osc_en_o        <= 1'b1;
			timer_en_clr_o  <= 1'b0;
			prescaler_clr_o <= 1'b0;
		end else begin
			core_run_o      <= !in_rst && (mode_q == RWWC_RUN) && !stop_enter && !wait_enter;
			osc_en_o        <= (mode_q != RWWC_STOP) && !stop_enter;
			timer_en_clr_o  <= stop_enter;
			prescaler_clr_o <= stop_enter;
		end
	end

	// interrupt mask bit
	always_ff @(posedge clk_i) begin
		if (rst_i || in_rst)
			mask_o <= 1'b1;
		else if (stop_enter || wait_enter)
			mask_o <= 1'b0;
		else if (mask_set_i)
			mask_o <= 1'b1;
		else if (mask_clr_i)
			mask_o <= 1'b0;
	end

	// external latch: a new edge in the clearing cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i || in_rst)
			ext_pend_q <= 1'b0;
		else if (ext_fall)
			ext_pend_q <= 1'b1;
		else if (ext_latch_clr_i)
			ext_pend_q <= 1'b0;
	end

	// vector selection at instruction end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vec_o <= '{valid: 1'b1, vector: `RWWC_VEC_RESET};
		end else if (in_rst) begin
			vec_o <= '{valid: 1'b1, vector: `RWWC_VEC_RESET};
		end else if (insn_end_i && !mask_o && (mode_q == RWWC_RUN)) begin
			if (ext_req)
				vec_o <= '{valid: 1'b1, vector: `RWWC_VEC_EXT};
			else if (tim_req && !stop_enter)
				vec_o <= '{valid: 1'b1, vector: `RWWC_VEC_TIMER};
			else if (ser_req)
				vec_o <= '{valid: 1'b1, vector: `RWWC_VEC_SERIAL};
			else if (spi_req)
				vec_o <= '{valid: 1'b1, vector: `RWWC_VEC_SPI};
			else
				vec_o <= '{valid: 1'b0, vector: vec_o.vector};
		end else begin
			vec_o <= '{valid: 1'b0, vector: vec_o.vector};
		end
	end

	// bus-rate enable for the watchdog
	logic [BDW-1:0] div_q;
	logic           tick;
	always_ff @(posedge clk_i) begin
		if (rst_i || div_q == BDW'(BUS_DIV - 1))
			div_q <= '0;
		else
			div_q <= div_q + 1'b1;
	end
	// stop halts the clock, so no bus ticks while stopped
	assign tick = (div_q == BDW'(BUS_DIV - 1)) && (mode_q != RWWC_STOP);

	// watchdog clear write: data bit 0 low
	wire wd_hit = bus_wr_i && (bus_addr_i == `RWWC_WDOG_CLR_ADDR);
	wire wd_sw_clr = wd_hit && !bus_wdata_i[`RWWC_WDOG_CLR_BIT];
	// reset exit from stop clears from reset entry through the whole delay; interrupt exit keeps the count
	wire wd_clr = wd_sw_clr || stop_enter || in_rst;
	rwwc_wdog #(.W(`RWWC_WDOG_BITS)) u_wdog (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.enable_i  (WDOG_OPTION && !self_check_i),
		.tick_i    (tick),
		.clear_i   (wd_clr),
		.timeout_o (wdog_to),
		.count_o   ()
	);
	always_ff @(posedge clk_i) begin
		if (rst_i)
			wdog_timeout_o <= 1'b0;
		else
			wdog_timeout_o <= wdog_to;
	end

	// reads of the clear location see ROM only
	always_ff @(posedge clk_i) begin
		if (rst_i)
			bus_rdata_o <= 8'h00;
		else if (bus_rd_i)
			bus_rdata_o <= rom_byte_i;
	end
endmodule : rwwc_ctrl
`default_nettype wire

// file: dv/rwwc_props.sv
// port assertions for the reset, wakeup and watchdog controller
// assumes binding onto rwwc_ctrl, single clock domain
`timescale 1ns/1ps
`default_nettype none
`include "rwwc_consts.svh"
module rwwc_props
	import rwwc_pkg::*;
(
	// clock and reset
	input wire logic         clk_i,
	input wire logic         rst_i,
	// inputs watched
	input wire logic         reset_n_i,
	input wire logic         self_check_i,
	input wire logic         bus_rd_i,
	input wire logic [7:0]   rom_byte_i,
	input wire logic         insn_end_i,
	input wire logic         stop_req_i,
	input wire logic         wait_req_i,
	input wire rwwc_periph_s periph_i,
	// outputs watched
	input wire logic [7:0]   bus_rdata_o,
	input wire logic         sys_rst_o,
	input wire logic         mask_o,
	input wire rwwc_vec_s    vec_o,
	input wire logic         core_run_o,
	input wire logic         osc_en_o,
	input wire logic         timer_en_clr_o,
	input wire logic         prescaler_clr_o,
	input wire logic         wdog_timeout_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	property p_mask; insn_end_i && mask_o |=> !vec_o.valid || sys_rst_o; endproperty
	a_mask: assert property (p_mask) else $error("vector while masked");
	property p_tmr; insn_end_i && !mask_o && core_run_o && !sys_rst_o
		&& |(periph_i.timer_flags & periph_i.timer_en)
		|=> vec_o.valid && vec_o.vector inside {`RWWC_VEC_EXT, `RWWC_VEC_TIMER}; endproperty
	a_tmr: assert property (p_tmr) else $error("timer request not vectored");
	property p_rng; vec_o.valid && !sys_rst_o && !$past(sys_rst_o)
		|-> vec_o.vector inside {`RWWC_VEC_EXT, `RWWC_VEC_TIMER, `RWWC_VEC_SERIAL, `RWWC_VEC_SPI}; endproperty
	a_rng: assert property (p_rng) else $error("bad vector");
	property p_stp; stop_req_i && core_run_o && !sys_rst_o
		|=> timer_en_clr_o && prescaler_clr_o && !mask_o && !osc_en_o; endproperty
	a_stp: assert property (p_stp) else $error("stop entry wrong");
	property p_stz; !osc_en_o && insn_end_i |=> !vec_o.valid; endproperty
	a_stz: assert property (p_stz) else $error("vector in stop");
	property p_rsv; sys_rst_o |-> mask_o && vec_o.vector == `RWWC_VEC_RESET; endproperty
	a_rsv: assert property (p_rsv) else $error("reset state wrong");
	property p_wdr; wdog_timeout_o |-> ##[0:2] sys_rst_o; endproperty
	a_wdr: assert property (p_wdr) else $error("timeout gave no reset");
	property p_slf; self_check_i |-> !wdog_timeout_o; endproperty
	a_slf: assert property (p_slf) else $error("timeout in self check");
	property p_pin; !reset_n_i [*8] |-> ##[0:4] sys_rst_o; endproperty
	a_pin: assert property (p_pin) else $error("pin reset missed");
	property p_rd; bus_rd_i |=> bus_rdata_o == $past(rom_byte_i); endproperty
	a_rd: assert property (p_rd) else $error("read data wrong");
	property p_wt; wait_req_i && core_run_o && !sys_rst_o |=> !mask_o && osc_en_o; endproperty
	a_wt: assert property (p_wt) else $error("wait entry wrong");
	c_ext: cover property (vec_o.valid && vec_o.vector == `RWWC_VEC_EXT);
	c_stop: cover property (!osc_en_o);
	c_pin: cover property (sys_rst_o && !reset_n_i);
endmodule : rwwc_props
bind rwwc_ctrl rwwc_props u_props (.clk_i, .rst_i, .reset_n_i, .self_check_i, .bus_rd_i, .rom_byte_i,
	.insn_end_i, .stop_req_i, .wait_req_i, .periph_i, .bus_rdata_o, .sys_rst_o, .mask_o, .vec_o,
	.core_run_o, .osc_en_o, .timer_en_clr_o, .prescaler_clr_o, .wdog_timeout_o);
`default_nettype wire

// file: dv/rwwc_core_model.sv
// core stand-in: reacts to a taken vector as the interrupt sequence does
// assumes vec_i.valid is a one-cycle pulse outside reset
`timescale 1ns/1ps
`default_nettype none
`include "rwwc_consts.svh"
module rwwc_core_model
	import rwwc_pkg::*;
(
	// clock and reset
	input  wire logic      clk_i,
	input  wire logic      rst_i,
	// from the controller
	input  wire rwwc_vec_s vec_i,
	input  wire logic      sys_rst_i,
	// to the controller
	output logic           latch_clr_o,
	output logic           mask_set_o
);
	// stacking sets the mask; the first service step drops the pin latch
	always_ff @(posedge clk_i) begin
		latch_clr_o <= !rst_i && !sys_rst_i && vec_i.valid && vec_i.vector == `RWWC_VEC_EXT;
		mask_set_o  <= !rst_i && !sys_rst_i && vec_i.valid;
	end
endmodule : rwwc_core_model
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the reset, wakeup and watchdog controller
// assumes POR_CYCLES shortened to 16; watchdog expiry is left to assertions
`timescale 1ns/1ps
`default_nettype none
`include "rwwc_consts.svh"
module tb_top;
	import rwwc_pkg::*;
	logic clk_i, rst_i, ext_irq_n_i, reset_n_i, self_check_i, bus_wr_i, bus_rd_i, insn_end_i;
	logic ext_latch_clr_i, mask_set_i, mask_clr_i, stop_req_i, wait_req_i;
	logic sys_rst_o, mask_o, core_run_o, osc_en_o, timer_en_clr_o, prescaler_clr_o, wdog_timeout_o;
	logic [7:0] portb_i, bus_wdata_i, rom_byte_i, bus_rdata_o;
	logic [12:0] bus_addr_i;
	rwwc_periph_s periph_i;
	rwwc_vec_s vec_o;
	int mismatches, samples_checked;
	rwwc_ctrl #(.POR_CYCLES(16), .PORTB_IRQ_EN(8'h01)) dut (.clk_i, .rst_i, .ext_irq_n_i, .reset_n_i, .portb_i, .self_check_i,
		.bus_wr_i, .bus_rd_i, .bus_addr_i, .bus_wdata_i, .rom_byte_i, .bus_rdata_o, .insn_end_i,
		.ext_latch_clr_i, .mask_set_i, .mask_clr_i, .stop_req_i, .wait_req_i, .periph_i, .sys_rst_o,
		.mask_o, .vec_o, .core_run_o, .osc_en_o, .timer_en_clr_o, .prescaler_clr_o, .wdog_timeout_o);
	rwwc_core_model core (.clk_i, .rst_i, .vec_i(vec_o), .sys_rst_i(sys_rst_o),
		.latch_clr_o(ext_latch_clr_i), .mask_set_o(mask_set_i));
	initial begin
		clk_i = 0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic wt(ref logic s, input logic v);
		for (int i = 0; i < 60 && s !== v; i++) @(posedge clk_i);
	endtask : wt
	// clr lowers the mask first; e of zero means no vector expected
	task automatic svc(input bit clr, input logic [12:0] e);
		mask_clr_i <= clr;
		@(posedge clk_i);
		mask_clr_i <= 0;
		insn_end_i <= 1;
		@(posedge clk_i);
		insn_end_i <= 0;
		#1;
		if (e == 0)
			chk(vec_o.valid, 0);
		else
			chk({2'b0, vec_o.valid, vec_o.vector}, {3'b001, e});
		// core model sets the mask a cycle after a vector; let that pulse pass first
		repeat (2) @(posedge clk_i);
	endtask : svc
	task automatic t_src;
		rwwc_periph_s p;
		logic [12:0] e;
		for (int i = 0; i < 10; i++) begin
			p = '0;
			if (i < 3) begin
				p.timer_flags[i] = 1;
				p.timer_en[i] = 1;
				e = `RWWC_VEC_TIMER;
			end else if (i < 8) begin
				p.serial_flags[i-3] = 1;
				p.serial_en[i-3] = 1;
				e = `RWWC_VEC_SERIAL;
			end else begin
				p.spi_flags[i-8] = 1;
				p.spi_en[i-8] = 1;
				e = `RWWC_VEC_SPI;
			end
			periph_i <= p;
			svc(1, e);
		end
		periph_i <= '0;
	endtask : t_src
	task automatic t_ext(input bit tmr);
		periph_i.timer_flags[0] <= tmr;
		periph_i.timer_en[0] <= tmr;
		ext_irq_n_i <= 0;
		repeat (8) @(posedge clk_i);
		ext_irq_n_i <= 1;
		svc(1, `RWWC_VEC_EXT);
		svc(1, tmr ? `RWWC_VEC_TIMER : 13'h0);
		periph_i <= '0;
	endtask : t_ext
	task automatic t_pb;
		portb_i[0] <= 0;
		repeat (8) @(posedge clk_i);
		portb_i[0] <= 1;
		svc(1, `RWWC_VEC_EXT);
		svc(1, 13'h0);
	endtask : t_pb
	task automatic t_stop;
		periph_i.timer_flags[1] <= 1;
		periph_i.timer_en[1] <= 1;
		stop_req_i <= 1;
		@(posedge clk_i);
		stop_req_i <= 0;
		#1;
		chk({osc_en_o, timer_en_clr_o, prescaler_clr_o, mask_o}, 16'h6);
		repeat (10) @(posedge clk_i);
		chk(osc_en_o, 0);
		periph_i <= '0;
		ext_irq_n_i <= 0;
		wt(osc_en_o, 1);
		ext_irq_n_i <= 1;
		chk(osc_en_o, 1);
		wt(core_run_o, 1);
		svc(1, `RWWC_VEC_EXT);
	endtask : t_stop
	task automatic t_wait;
		wait_req_i <= 1;
		@(posedge clk_i);
		wait_req_i <= 0;
		#1;
		chk({core_run_o, mask_o}, 0);
		periph_i.spi_flags[0] <= 1;
		periph_i.spi_en[0] <= 1;
		wt(core_run_o, 1);
		chk(core_run_o, 1);
		periph_i <= '0;
	endtask : t_wait
	task automatic t_bus;
		bus_addr_i <= `RWWC_WDOG_CLR_ADDR;
		bus_wdata_i <= 8'hfe;
		bus_wr_i <= 1;
		rom_byte_i <= 8'h5a;
		@(posedge clk_i);
		bus_wr_i <= 0;
		bus_rd_i <= 1;
		@(posedge clk_i);
		bus_rd_i <= 0;
		#1;
		chk(bus_rdata_o, 8'h5a);
		chk(wdog_timeout_o, 0);
	endtask : t_bus
	task automatic t_pin;
		reset_n_i <= 0;
		wt(sys_rst_o, 1);
		chk({sys_rst_o, mask_o, vec_o.vector}, {2'b11, `RWWC_VEC_RESET});
		reset_n_i <= 1;
		wt(sys_rst_o, 0);
		chk(sys_rst_o, 0);
	endtask : t_pin
	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	initial begin
		{ext_irq_n_i, reset_n_i, portb_i, rst_i} = '1;
		{self_check_i, bus_wr_i, bus_rd_i, bus_addr_i, bus_wdata_i, rom_byte_i, insn_end_i} = '0;
		{mask_clr_i, stop_req_i, wait_req_i, periph_i} = '0;
		repeat (5) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		#1;
		chk(sys_rst_o, 1);
		wt(sys_rst_o, 0);
		chk(sys_rst_o, 0);
		periph_i.timer_flags[2] <= 1;
		periph_i.timer_en[2] <= 1;
		svc(0, 0);
		svc(1, `RWWC_VEC_TIMER);
		t_src();
		t_ext(0);
		t_ext(1);
		t_pb();
		t_stop();
		t_wait();
		t_bus();
		t_pin();
		final_report();
	end
	initial begin
		#20000;
		mismatches++;
		final_report();
	end
endmodule : tb_top
`default_nettype wire
